// ---- rtl/cfpb_core.sv ----
// cfpb_core: phase generator, two-stage fetch/execute pipeline, data address former
// assumes synchronous program memory data on PMEM_RDATA_I by phase four, data memory read data by phase three
`timescale 1ns/100ps
`default_nettype none

module cfpb_core (
  // clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_I,
  // program memory
  output logic [20:0]      PMEM_ADDR_O,
  input  wire logic [15:0] PMEM_RDATA_I,
  // data memory
  output logic             DMEM_RD_O,
  output logic             DMEM_WR_O,
  output logic [11:0]      DMEM_ADDR_O,
  output logic [7:0]       DMEM_WDATA_O,
  input  wire logic [7:0]  DMEM_RDATA_I,
  // phase and status
  output logic [3:0]       PHASE_O,
  output logic             FLUSH_O,
  output logic             ZERO_FLAG_O,
  // avalon-mm slave
  input  wire logic [3:0]  AVS_ADDRESS_I,
  input  wire logic        AVS_READ_I,
  input  wire logic        AVS_WRITE_I,
  input  wire logic [31:0] AVS_WRITEDATA_I,
  input  wire logic [3:0]  AVS_BYTEENABLE_I,
  output logic [31:0]      AVS_READDATA_O,
  output logic             AVS_WAITREQUEST_O
);

  cfpb_pkg::cfpb_phase_e phase_reg, phase_next;
  cfpb_pkg::cfpb_exec_e  exec_reg, exec_next;
  logic [20:0] pc_reg, pc_next;
  logic [20:0] fa_reg, fa_next;            // address of the word being fetched this cycle
  logic [3:0]  phase_oh_reg, phase_oh_next; // one-hot phase seen on the pins
  logic [15:0] fetch_reg, fetch_next;      // word fetched last cycle
  logic [15:0] ir_reg, ir_next;            // instruction latch
  logic [15:0] first_reg, first_next;      // held first word of a pair
  logic [3:0]  bank_reg, bank_next;
  logic [7:0]  wreg_reg, wreg_next;
  logic [7:0]  opnd_reg, opnd_next;
  logic        zero_reg, zero_next;
  logic        run_reg, run_next;
  logic        flush_reg, flush_next;
  cfpb_pkg::cfpb_dmem_s dm_reg, dm_next;
  logic [31:0] rdata_reg, rdata_next;
  logic        wait_reg, wait_next;
  logic [11:0] ea;
  logic        impl;

  // access-bank or banked effective address for single-word data ops
  always_comb begin
    if (ir_reg[8]) begin
      ea = {bank_reg, ir_reg[7:0]};
    end else begin
      ea = {(ir_reg[7] ? cfpb_pkg::CFPB_TOP_BANK : 4'h0), ir_reg[7:0]};
    end
  end

  // implemented-bank lookup for the current address
  assign impl = cfpb_pkg::CFPB_BANKS_IMPL[dm_reg.addr[11:8]];

  // phase, fetch, execute and bus next-state
  always_comb begin
    phase_next = phase_reg;
    exec_next  = exec_reg;
    pc_next    = pc_reg;
    fa_next    = fa_reg;
    fetch_next = fetch_reg;
    ir_next    = ir_reg;
    first_next = first_reg;
    bank_next  = bank_reg;
    wreg_next  = wreg_reg;
    opnd_next  = opnd_reg;
    zero_next  = zero_reg;
    run_next   = run_reg;
    flush_next = flush_reg;
    dm_next    = dm_reg;
    rdata_next = rdata_reg;
    wait_next  = 1'b1;
    // divide by four
    case (phase_reg)
      cfpb_pkg::CFPB_PH1: phase_next = cfpb_pkg::CFPB_PH2;
      cfpb_pkg::CFPB_PH2: phase_next = cfpb_pkg::CFPB_PH3;
      cfpb_pkg::CFPB_PH3: phase_next = cfpb_pkg::CFPB_PH4;
      cfpb_pkg::CFPB_PH4: phase_next = cfpb_pkg::CFPB_PH1;
      default:            phase_next = cfpb_pkg::CFPB_PH1;
    endcase
    // one-hot copy registered alongside the phase state
    phase_oh_next = {phase_next == cfpb_pkg::CFPB_PH4, phase_next == cfpb_pkg::CFPB_PH3,
                     phase_next == cfpb_pkg::CFPB_PH2, phase_next == cfpb_pkg::CFPB_PH1};
    dm_next.rd = 1'b0;
    dm_next.wr = 1'b0;
    if (run_reg) begin
      case (phase_reg)
        cfpb_pkg::CFPB_PH1: begin
          // last cycle's fetch enters execute; counter advances
          ir_next    = fetch_reg;
          fa_next    = pc_reg;
          pc_next    = pc_reg + cfpb_pkg::CFPB_PC_STEP;
          flush_next = (exec_reg == cfpb_pkg::CFPB_EX_FLUSH);
          if (exec_reg == cfpb_pkg::CFPB_EX_WORD2) begin
            first_next = ir_reg;
          end
        end
        cfpb_pkg::CFPB_PH2: begin
          // operand read
          if (!flush_reg && exec_reg == cfpb_pkg::CFPB_EX_RUN) begin
            if (ir_reg[15:10] == cfpb_pkg::CFPB_OP_MOVF[5:0]) begin
              dm_next.rd   = 1'b1;
              dm_next.addr = ea;
            end
          end else if (!flush_reg && exec_reg == cfpb_pkg::CFPB_EX_WORD2
                       && ir_reg[15:12] == cfpb_pkg::CFPB_WORD2_TAG
                       && first_reg[15:12] == cfpb_pkg::CFPB_OP_MOVE) begin
            dm_next.rd   = 1'b1;
            dm_next.addr = first_reg[11:0];
          end
        end
        cfpb_pkg::CFPB_PH3: begin
          // catch read data; unimplemented reads give zero
          opnd_next = impl ? DMEM_RDATA_I : 8'h00;
        end
        cfpb_pkg::CFPB_PH4: begin
          fetch_next = PMEM_RDATA_I;
          exec_next  = cfpb_pkg::CFPB_EX_RUN;
          if (flush_reg) begin
            exec_next = cfpb_pkg::CFPB_EX_RUN;
          end else if (exec_reg == cfpb_pkg::CFPB_EX_WORD2) begin
            if (ir_reg[15:12] == cfpb_pkg::CFPB_WORD2_TAG) begin
              if (first_reg[15:8] == cfpb_pkg::CFPB_OP_JUMP) begin
                pc_next   = {ir_reg[11:0], first_reg[7:0], 1'b0};
                exec_next = cfpb_pkg::CFPB_EX_FLUSH;
              end else if (first_reg[15:12] == cfpb_pkg::CFPB_OP_MOVE) begin
                dm_next.wr    = 1'b1;
                dm_next.addr  = ir_reg[11:0];
                dm_next.wdata = opnd_reg;
              end
            end
          end else if (ir_reg[15:12] == cfpb_pkg::CFPB_WORD2_TAG) begin
            exec_next = cfpb_pkg::CFPB_EX_RUN;
          end else if (ir_reg[15:8] == cfpb_pkg::CFPB_OP_JUMP
                       || ir_reg[15:12] == cfpb_pkg::CFPB_OP_MOVE) begin
            exec_next = cfpb_pkg::CFPB_EX_WORD2;
          end else if (ir_reg[15:11] == cfpb_pkg::CFPB_OP_BRA) begin
            pc_next   = fa_reg + {{9{ir_reg[10]}}, ir_reg[10:0], 1'b0};
            exec_next = cfpb_pkg::CFPB_EX_FLUSH;
          end else if (ir_reg[15:8] == cfpb_pkg::CFPB_OP_LOADBANK) begin
            bank_next = ir_reg[3:0];
          end else if (ir_reg[15:10] == cfpb_pkg::CFPB_OP_MOVF[5:0]) begin
            zero_next = (opnd_reg == 8'h00);
            if (!ir_reg[9]) begin
              wreg_next = opnd_reg;
            end
          end else if (ir_reg[15:9] == {cfpb_pkg::CFPB_OP_MOVWF, 1'b1}) begin
            dm_next.wr    = 1'b1;
            dm_next.addr  = ea;
            dm_next.wdata = wreg_reg;
          end
        end
        default: ;
      endcase
    end
    // drop writes to unimplemented banks
    if (dm_next.wr && !cfpb_pkg::CFPB_BANKS_IMPL[dm_next.addr[11:8]]) begin
      dm_next.wr = 1'b0;
    end
    // avalon slave: one wait cycle then answer
    if ((AVS_READ_I || AVS_WRITE_I) && wait_reg) begin
      wait_next = 1'b0;
      case (AVS_ADDRESS_I)
        cfpb_pkg::CFPB_ADDR_BANK: rdata_next = {28'h0000000, bank_reg};
        cfpb_pkg::CFPB_ADDR_PC:   rdata_next = {11'h000, fa_reg[20:1], 1'b0};
        cfpb_pkg::CFPB_ADDR_CTRL: rdata_next = {31'h00000000, run_reg};
        cfpb_pkg::CFPB_ADDR_STAT: rdata_next = {16'h0000, wreg_reg, 5'h00, flush_reg, zero_reg,
                                                exec_reg == cfpb_pkg::CFPB_EX_WORD2};
        default:                  rdata_next = cfpb_pkg::CFPB_BAD_READ;
      endcase
    end
    // a write lands at the edge where the master sees waitrequest low
    if (AVS_WRITE_I && !wait_reg && AVS_BYTEENABLE_I[0]) begin
      if (AVS_ADDRESS_I == cfpb_pkg::CFPB_ADDR_BANK) begin
        bank_next = AVS_WRITEDATA_I[3:0];
      end else if (AVS_ADDRESS_I == cfpb_pkg::CFPB_ADDR_CTRL) begin
        run_next = AVS_WRITEDATA_I[0];
      end
    end
  end

  // register all state
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      phase_reg <= cfpb_pkg::CFPB_PH1;
      exec_reg  <= cfpb_pkg::CFPB_EX_FLUSH;
      pc_reg    <= cfpb_pkg::CFPB_PC_RESET;
      fa_reg    <= cfpb_pkg::CFPB_PC_RESET;
      phase_oh_reg <= 4'h1;
      fetch_reg <= cfpb_pkg::CFPB_NOP_WORD;
      ir_reg    <= cfpb_pkg::CFPB_NOP_WORD;
      first_reg <= cfpb_pkg::CFPB_NOP_WORD;
      bank_reg  <= cfpb_pkg::CFPB_BANK_RESET;
      wreg_reg  <= 8'h00;
      opnd_reg  <= 8'h00;
      zero_reg  <= 1'b0;
      run_reg   <= 1'b1;
      flush_reg <= 1'b1;
      dm_reg    <= '0;
      rdata_reg <= 32'h00000000;
      wait_reg  <= 1'b1;
    end else begin
      phase_reg <= phase_next;
      exec_reg  <= exec_next;
      pc_reg    <= {pc_next[20:1], 1'b0};
      fa_reg    <= {fa_next[20:1], 1'b0};
      phase_oh_reg <= phase_oh_next;
      fetch_reg <= fetch_next;
      ir_reg    <= ir_next;
      first_reg <= first_next;
      bank_reg  <= bank_next;
      wreg_reg  <= wreg_next;
      opnd_reg  <= opnd_next;
      zero_reg  <= zero_next;
      run_reg   <= run_next;
      flush_reg <= flush_next;
      dm_reg    <= dm_next;
      rdata_reg <= rdata_next;
      wait_reg  <= wait_next;
    end
  end

  // outputs straight from flip-flops
  assign PMEM_ADDR_O       = fa_reg;
  assign DMEM_RD_O         = dm_reg.rd;
  assign DMEM_WR_O         = dm_reg.wr;
  assign DMEM_ADDR_O       = dm_reg.addr;
  assign DMEM_WDATA_O      = dm_reg.wdata;
  assign FLUSH_O           = flush_reg;
  assign ZERO_FLAG_O       = zero_reg;
  assign AVS_READDATA_O    = rdata_reg;
  assign AVS_WAITREQUEST_O = wait_reg;
  assign PHASE_O           = phase_oh_reg;

endmodule // cfpb_core

`default_nettype wire

// ---- rtl/cfpb_pkg.sv ----
// cfpb_pkg: constants and carriers for the fetch pipeline and bank addressing block
// assumes a single 40 MHz core clock and an external program and data memory
package cfpb_pkg;

  // phase encoding (gray sequence)
  typedef enum logic [1:0] {
    CFPB_PH1 = 2'h0,
    CFPB_PH2 = 2'h1,
    CFPB_PH3 = 2'h3,
    CFPB_PH4 = 2'h2
  } cfpb_phase_e;

  // execute-slot state: normal, waiting for second word, flushed
  typedef enum logic [1:0] {
    CFPB_EX_RUN   = 2'h0,
    CFPB_EX_WORD2 = 2'h1,
    CFPB_EX_FLUSH = 2'h3
  } cfpb_exec_e;

  localparam int          CFPB_PC_W        = 21;
  localparam logic [20:0] CFPB_PC_RESET    = 21'h000000;
  localparam logic [20:0] CFPB_PC_STEP     = 21'h000002;
  localparam logic [15:0] CFPB_NOP_WORD    = 16'h0000;
  localparam logic [3:0]  CFPB_WORD2_TAG   = 4'hF;
  localparam logic [3:0]  CFPB_BANK_RESET  = 4'h0;
  localparam logic [3:0]  CFPB_TOP_BANK    = 4'hF;
  localparam logic [15:0] CFPB_BANKS_IMPL  = 16'hFFFF;

  // opcode patterns (top bits of first word)
  localparam logic [3:0]  CFPB_OP_JUMP_HI  = 4'hE;   // 1110_1111 absolute jump
  localparam logic [7:0]  CFPB_OP_JUMP     = 8'hEF;
  localparam logic [3:0]  CFPB_OP_MOVE     = 4'hC;   // full address move
  localparam logic [4:0]  CFPB_OP_BRA      = 5'h1A;  // 1101_0 relative branch
  localparam logic [7:0]  CFPB_OP_LOADBANK = 8'h01;  // 0000_0001 load bank literal
  localparam logic [5:0]  CFPB_OP_MOVWF    = 6'h1B;  // 0110_111a register store
  localparam logic [5:0]  CFPB_OP_MOVF     = 6'h14;  // 0101_00da register load

  // Avalon register map (byte addresses)
  localparam logic [3:0]  CFPB_ADDR_BANK   = 4'h0;
  localparam logic [3:0]  CFPB_ADDR_PC     = 4'h4;
  localparam logic [3:0]  CFPB_ADDR_CTRL   = 4'h8;
  localparam logic [3:0]  CFPB_ADDR_STAT   = 4'hC;
  localparam logic [31:0] CFPB_BAD_READ    = 32'h00000000;

  // data memory request carrier
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } cfpb_dmem_s;

endpackage

// ---- tb/cfpb_chk.sv ----
// cfpb_chk: phase, strobe, flush and bus timing checks on the core ports
// assumes one core clock and an active-high asynchronous reset
`timescale 1ns/100ps
`default_nettype none
module cfpb_chk (
  // clock and reset
  input wire logic        CORE_CLK_I,
  input wire logic        RST_I,
  // pipeline side
  input wire logic [20:0] PMEM_ADDR_O,
  input wire logic        DMEM_RD_O,
  input wire logic        DMEM_WR_O,
  input wire logic [3:0]  PHASE_O,
  input wire logic        FLUSH_O,
  // register bus
  input wire logic [3:0]  AVS_ADDRESS_I,
  input wire logic        AVS_READ_I,
  input wire logic        AVS_WRITE_I,
  input wire logic [31:0] AVS_READDATA_O,
  input wire logic        AVS_WAITREQUEST_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  // phases two to four of one instruction cycle, then the next phase one
  sequence s_quad;
    PHASE_O[1] ##1 PHASE_O[2] ##1 PHASE_O[3] ##1 PHASE_O[0];
  endsequence
  // bus answer: one low cycle of waitrequest, then idle high
  sequence s_answer;
    !AVS_WAITREQUEST_O ##1 AVS_WAITREQUEST_O;
  endsequence
  property p_onehot; $onehot(PHASE_O); endproperty
  property p_quad; PHASE_O[0] |=> s_quad; endproperty
  property p_pc_even; !PMEM_ADDR_O[0]; endproperty
  property p_pc_hold; (PHASE_O[2] || PHASE_O[3]) |-> $stable(PMEM_ADDR_O); endproperty
  property p_rd_slot; DMEM_RD_O |-> PHASE_O[2]; endproperty
  property p_wr_slot; DMEM_WR_O |-> PHASE_O[0]; endproperty
  property p_flush_rd; FLUSH_O && PHASE_O[2] |-> !DMEM_RD_O; endproperty
  property p_flush_wr; FLUSH_O && PHASE_O[3] |=> !DMEM_WR_O; endproperty
  property p_wait; (AVS_READ_I || AVS_WRITE_I) && AVS_WAITREQUEST_O |=> s_answer; endproperty
  property p_bank_hi; AVS_READ_I && !AVS_WAITREQUEST_O && AVS_ADDRESS_I == 4'h0 |-> AVS_READDATA_O[31:4] == 28'h0;
  endproperty
  a_onehot:
    assert property (p_onehot) else $error("phase not one-hot");
  a_quad:
    assert property (p_quad) else $error("phase order broken");
  a_pc_even:
    assert property (p_pc_even) else $error("odd program address");
  a_pc_hold:
    assert property (p_pc_hold) else $error("program counter moved late");
  a_rd_slot:
    assert property (p_rd_slot) else $error("read strobe off phase three");
  a_wr_slot:
    assert property (p_wr_slot) else $error("write strobe off slot");
  a_flush_rd:
    assert property (p_flush_rd) else $error("read in flushed slot");
  a_flush_wr:
    assert property (p_flush_wr) else $error("write in flushed slot");
  a_wait:
    assert property (p_wait) else $error("bus answer late");
  a_bank_hi:
    assert property (p_bank_hi) else $error("bank pointer upper bits set");
endmodule // cfpb_chk
bind cfpb_core cfpb_chk u_chk (.CORE_CLK_I, .RST_I, .PMEM_ADDR_O, .DMEM_RD_O, .DMEM_WR_O, .PHASE_O, .FLUSH_O,
  .AVS_ADDRESS_I, .AVS_READ_I, .AVS_WRITE_I, .AVS_READDATA_O, .AVS_WAITREQUEST_O);
`default_nettype wire

// ---- tb/cfpb_mem.sv ----
// cfpb_mem: program word array and 4 KB data array facing the core
// assumes combinational reads, writes on the core clock
`timescale 1ns/100ps
`default_nettype none
module cfpb_mem (
  input wire logic        clk_i,
  input wire logic [20:0] pmem_addr_i,
  output logic [15:0]     pmem_rdata_o,
  input wire logic        dmem_rd_i,
  input wire logic        dmem_wr_i,
  input wire logic [11:0] dmem_addr_i,
  input wire logic [7:0]  dmem_wdata_i,
  output logic [7:0]      dmem_rdata_o
);
  logic [15:0] prog [0:15];
  logic [7:0]  data [0:4095];
  // test program: bank load, stores, move, lone second word, jump, branches
  initial begin
    prog = '{16'h0105, 16'h6F23, 16'h6E90, 16'h6E10, 16'hC123, 16'hF456, 16'hF777, 16'hEF0A,
             16'hF000, 16'h6E33, 16'h5100, 16'hD001, 16'h6E44, 16'hD7FF, 16'h0000, 16'h0000};
    foreach (data[i]) data[i] = 8'h00;
  end
  // word at the byte address, bit zero ignored
  assign pmem_rdata_o = prog[pmem_addr_i[4:1]];
  // cell only while strobed, a wrong pattern otherwise
  assign dmem_rdata_o = dmem_rd_i ? data[dmem_addr_i] : ~data[dmem_addr_i];
  // write port
  always @(posedge clk_i) if (dmem_wr_i) data[dmem_addr_i] <= dmem_wdata_i;
endmodule // cfpb_mem
`default_nettype wire

// ---- tb/core_fetch_pipeline_bank_addressing_tb.sv ----
// core_fetch_pipeline_bank_addressing_tb: runs a small program and pokes the register bus
// assumes the core, its checker bind and cfpb_mem are compiled first
`timescale 1ns/100ps
`default_nettype none
module core_fetch_pipeline_bank_addressing_tb;
  logic        clk = 1'b0, rst = 1'b1, drd, dwr, flush, zflag, aw, ard = 1'b0, awr = 1'b0;
  logic [20:0] paddr;
  logic [15:0] pdata;
  logic [11:0] daddr;
  logic [7:0]  dwd, drdat;
  logic [3:0]  phase, aaddr = 4'h0;
  logic [31:0] awd = 32'h0, ard_q, q, d;
  int          n_errors = 0, num_checks = 0, cyc = 0, seen_mv = 0, seen_ld = 0;
  int          seed = 32'h2875;
  logic [11:0] wq [$] = '{12'h523, 12'hF90, 12'h010, 12'h456};
  // core clock 40 MHz
  always #12.5 clk = ~clk;
  cfpb_core DUT (.CORE_CLK_I(clk), .RST_I(rst), .PMEM_ADDR_O(paddr), .PMEM_RDATA_I(pdata),
    .DMEM_RD_O(drd), .DMEM_WR_O(dwr), .DMEM_ADDR_O(daddr), .DMEM_WDATA_O(dwd), .DMEM_RDATA_I(drdat),
    .PHASE_O(phase), .FLUSH_O(flush), .ZERO_FLAG_O(zflag), .AVS_ADDRESS_I(aaddr), .AVS_READ_I(ard),
    .AVS_WRITE_I(awr), .AVS_WRITEDATA_I(awd), .AVS_BYTEENABLE_I(4'hF), .AVS_READDATA_O(ard_q),
    .AVS_WAITREQUEST_O(aw));
  cfpb_mem u_mem (.clk_i(clk), .pmem_addr_i(paddr), .pmem_rdata_o(pdata), .dmem_rd_i(drd), .dmem_wr_i(dwr),
    .dmem_addr_i(daddr), .dmem_wdata_i(dwd), .dmem_rdata_o(drdat));
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  // verdict
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // one bus transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
    aaddr <= a;
    awr <= wr;
    ard <= !wr;
    awd <= wd;
    do @(posedge clk); while (aw !== 1'b0);
    rd = ard_q;
    awr <= 1'b0;
    ard <= 1'b0;
    @(posedge clk);
  endtask
  // model of data traffic: writes in program order, reads tallied
  always @(posedge clk) begin
    if (!rst && dwr === 1'b1)
      chk("wr_addr", daddr, wq.size() ? wq.pop_front() : 12'hFFF);
    if (!rst && drd === 1'b1) begin
      seen_mv += (daddr == 12'h123);
      seen_ld += (daddr == 12'h500);
      chk("rd_skip", daddr == 12'h033 || daddr == 12'h044, 0);
    end
  end
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      conclude();
    end
  end
  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    chk("pc_rst", paddr, 0);
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (400) @(posedge clk);
    chk("wr_left", wq.size(), 0);
    chk("mv_src", seen_mv != 0, 1);
    chk("ld_src", seen_ld != 0, 1);
    chk("zflag", zflag, 1);
    bus(0, 4'h4, 0, q);
    chk("pc", q == 32'h1A || q == 32'h1C, 1);
    bus(0, 4'hC, 0, q);
    chk("stat_z", q[1], 1);
    bus(0, 4'h8, 0, q);
    chk("run", q[0], 1);
    bus(0, 4'h2, 0, q);
    chk("unmapped", q, 0);
    repeat (20) begin
      d = $random(seed);
      bus(1, 4'h0, d, q);
      bus(0, 4'h0, 0, q);
      chk("bank", q, {28'h0, d[3:0]});
    end
    conclude();
  end
endmodule // core_fetch_pipeline_bank_addressing_tb
`default_nettype wire
